// File: core/ufm_pkg.sv
// Package of constants for the queue threshold marker block.
package ufm_pkg;
  // ****************************************************************
  // Register map (byte addresses on the AXI4-Lite bus)
  // ****************************************************************
  localparam logic [3:0] UFM_OFF_THRESH = 4'h0;
  localparam logic [3:0] UFM_OFF_STATUS = 4'h4;
  localparam logic [3:0] UFM_OFF_ENABLE = 4'h8;
  localparam logic [3:0] UFM_OFF_CLEAR  = 4'hC;
  // ****************************************************************
  // Field layout, reset values, threshold step and response codes
  // ****************************************************************
  localparam int          UFM_TX_LSB     = 8;
  localparam int          UFM_RX_LSB     = 0;
  localparam int          UFM_FLD_W      = 4;
  localparam logic [15:0] UFM_THRESH_WMASK = 16'h0F0F;
  localparam logic [15:0] UFM_THRESH_RST = 16'h0000;
  localparam int          UFM_STEP_SHIFT = 2;
  localparam int          UFM_BIT_RX     = 0;
  localparam int          UFM_BIT_TX     = 1;
  localparam logic [1:0]  UFM_IRQ_RST    = 2'h0;
  localparam logic [1:0]  UFM_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  UFM_RESP_SLVERR = 2'h2;
endpackage

// File: core/ufm_level_cmp.sv
// Threshold comparator for one queue.
`timescale 1ns/10ps
`default_nettype none
module ufm_level_cmp #(
  parameter int CNT_W = 7
) (
  input  wire logic [3:0]       i_code,
  input  wire logic [CNT_W-1:0] i_count,
  output logic                  o_hit
);
  import ufm_pkg::*;
  logic [CNT_W+1:0] limit;
  always_comb
  begin
    limit = {{(CNT_W-2){1'b0}}, i_code} << UFM_STEP_SHIFT;
    o_hit = (i_code != 4'h0) && ({2'b00, i_count} >= limit);
  end
endmodule
`default_nettype wire

// File: core/ufm_marker.sv
// Queue threshold marker with AXI4-Lite registers and interrupt.
`timescale 1ns/10ps
`default_nettype none
module ufm_marker #(
  parameter int CNT_W = 7
) (
  input  wire logic             I_CLK,
  input  wire logic             I_SRST,
  input  wire logic [CNT_W-1:0] I_TX_EMPTY_SLOTS,
  input  wire logic [CNT_W-1:0] I_RX_BYTES_HELD,
  input  wire logic [3:0]       I_AWADDR,
  input  wire logic             I_AWVALID,
  output logic                  O_AWREADY,
  input  wire logic [31:0]      I_WDATA,
  input  wire logic [3:0]       I_WSTRB,
  input  wire logic             I_WVALID,
  output logic                  O_WREADY,
  output logic [1:0]            O_BRESP,
  output logic                  O_BVALID,
  input  wire logic             I_BREADY,
  input  wire logic [3:0]       I_ARADDR,
  input  wire logic             I_ARVALID,
  output logic                  O_ARREADY,
  output logic [31:0]           O_RDATA,
  output logic [1:0]            O_RRESP,
  output logic                  O_RVALID,
  input  wire logic             I_RREADY,
  output logic                  O_TX_HALF_FLAG,
  output logic                  O_RX_HALF_FLAG,
  output logic                  O_IRQ
);
  import ufm_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] thresh_q;
  logic [1:0]  status_q;
  logic [1:0]  enable_q;
  logic [3:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic        tx_hit;
  logic        rx_hit;
  logic        do_write;
  logic [1:0]  clear_d;
  logic [3:0]  tx_code;
  logic [3:0]  rx_code;

  // Queue counts come from logic on I_CLK, so no synchroniser is placed here.
  assign tx_code = thresh_q[UFM_TX_LSB +: UFM_FLD_W];
  assign rx_code = thresh_q[UFM_RX_LSB +: UFM_FLD_W];

  ufm_level_cmp #(.CNT_W(CNT_W)) u_tx_cmp (
    .i_code  (tx_code),
    .i_count (I_TX_EMPTY_SLOTS),
    .o_hit   (tx_hit)
  );

  ufm_level_cmp #(.CNT_W(CNT_W)) u_rx_cmp (
    .i_code  (rx_code),
    .i_count (I_RX_BYTES_HELD),
    .o_hit   (rx_hit)
  );

  // ****************************************************************
  // Write channel
  // ****************************************************************
  assign do_write = aw_have_q && w_have_q && !O_BVALID;

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 4'h0;
      O_AWREADY <= 1'b0;
    end
    else if (do_write)
    begin
      aw_have_q <= 1'b0;
      O_AWREADY <= 1'b0;
    end
    else if (!aw_have_q && !O_AWREADY)
    begin
      O_AWREADY <= 1'b1;
    end
    else if (O_AWREADY && I_AWVALID)
    begin
      aw_have_q <= 1'b1;
      awaddr_q  <= I_AWADDR;
      O_AWREADY <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      w_have_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      O_WREADY <= 1'b0;
    end
    else if (do_write)
    begin
      w_have_q <= 1'b0;
      O_WREADY <= 1'b0;
    end
    else if (!w_have_q && !O_WREADY)
    begin
      O_WREADY <= 1'b1;
    end
    else if (O_WREADY && I_WVALID)
    begin
      w_have_q <= 1'b1;
      wdata_q  <= I_WDATA;
      wstrb_q  <= I_WSTRB;
      O_WREADY <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      O_BVALID <= 1'b0;
      O_BRESP  <= UFM_RESP_OKAY;
    end
    else if (do_write)
    begin
      O_BVALID <= 1'b1;
      O_BRESP  <= (awaddr_q[1:0] == 2'b00) ? UFM_RESP_OKAY : UFM_RESP_SLVERR;
    end
    else if (O_BVALID && I_BREADY)
    begin
      O_BVALID <= 1'b0;
    end
  end

  // Reserved threshold bits are never stored, so software that breaks the zero-write convention is harmless.
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      thresh_q <= UFM_THRESH_RST;
    end
    else if (do_write && awaddr_q == UFM_OFF_THRESH)
    begin
      if (wstrb_q[0])
        thresh_q[7:0] <= wdata_q[7:0] & UFM_THRESH_WMASK[7:0];
      if (wstrb_q[1])
        thresh_q[15:8] <= wdata_q[15:8] & UFM_THRESH_WMASK[15:8];
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      enable_q <= UFM_IRQ_RST;
    else if (do_write && awaddr_q == UFM_OFF_ENABLE && wstrb_q[0])
      enable_q <= wdata_q[1:0];
  end

  // ****************************************************************
  // Half flags, sticky status and interrupt
  // ****************************************************************
  always_comb
  begin
    clear_d = 2'b00;
    if (do_write && awaddr_q == UFM_OFF_CLEAR && wstrb_q[0])
      clear_d = wdata_q[1:0];
  end

  // Flags are registered each cycle from the live comparison, one cycle behind the counts.
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      O_TX_HALF_FLAG <= 1'b0;
      O_RX_HALF_FLAG <= 1'b0;
    end
    else
    begin
      O_TX_HALF_FLAG <= tx_hit;
      O_RX_HALF_FLAG <= rx_hit;
    end
  end

  // A new hit in the clearing cycle wins over the clear.
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      status_q <= UFM_IRQ_RST;
    else
    begin
      status_q[UFM_BIT_TX] <= tx_hit | (status_q[UFM_BIT_TX] & ~clear_d[UFM_BIT_TX]);
      status_q[UFM_BIT_RX] <= rx_hit | (status_q[UFM_BIT_RX] & ~clear_d[UFM_BIT_RX]);
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      O_IRQ <= 1'b0;
    else
      O_IRQ <= |(status_q & enable_q);
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0000_0000;
      O_RRESP   <= UFM_RESP_OKAY;
    end
    else if (O_RVALID)
    begin
      if (I_RREADY)
        O_RVALID <= 1'b0;
    end
    else if (!O_ARREADY)
    begin
      O_ARREADY <= 1'b1;
    end
    else if (I_ARVALID)
    begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b1;
      O_RRESP   <= UFM_RESP_OKAY;
      case (I_ARADDR)
        UFM_OFF_THRESH: O_RDATA <= {16'h0000, thresh_q};
        UFM_OFF_STATUS: O_RDATA <= {30'h0000_0000, status_q};
        UFM_OFF_ENABLE: O_RDATA <= {30'h0000_0000, enable_q};
        UFM_OFF_CLEAR:  O_RDATA <= 32'h0000_0000;
        default:
        begin
          O_RDATA <= 32'h0000_0000;
          O_RRESP <= UFM_RESP_SLVERR;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: verif/ufm_marker_monitor.sv
// Checker of handshakes and flag levels of the queue threshold marker.
`timescale 1ns/10ps
`default_nettype none
module ufm_marker_monitor #(
  parameter int CNT_W = 7
) (
  input wire logic             I_CLK,
  input wire logic             I_SRST,
  input wire logic [CNT_W-1:0] I_TX_EMPTY_SLOTS,
  input wire logic [CNT_W-1:0] I_RX_BYTES_HELD,
  input wire logic             I_AWVALID,
  input wire logic             O_AWREADY,
  input wire logic             O_BVALID,
  input wire logic             I_BREADY,
  input wire logic             I_ARVALID,
  input wire logic             O_ARREADY,
  input wire logic             O_RVALID,
  input wire logic             I_RREADY,
  input wire logic             O_TX_HALF_FLAG,
  input wire logic             O_RX_HALF_FLAG,
  input wire logic             O_IRQ
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_rst; $fell(I_SRST) |-> !O_IRQ && !O_BVALID && !O_RVALID && !O_TX_HALF_FLAG; endproperty
  property p_bhold; O_BVALID && !I_BREADY |=> O_BVALID; endproperty
  property p_bdrop; O_BVALID && I_BREADY |=> !O_BVALID; endproperty
  property p_brise; I_AWVALID && O_AWREADY |-> ##[1:3] O_BVALID; endproperty
  property p_rrise; I_ARVALID && O_ARREADY |=> O_RVALID; endproperty
  property p_rdrop; O_RVALID && I_RREADY |=> !O_RVALID; endproperty
  property p_awdrop; I_AWVALID && O_AWREADY |=> !O_AWREADY; endproperty
  // No code reaches below four, so a count under four can never meet a threshold.
  property p_txlow; I_TX_EMPTY_SLOTS < 4 |=> !O_TX_HALF_FLAG; endproperty
  property p_rxlow; I_RX_BYTES_HELD < 4 |=> !O_RX_HALF_FLAG; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  a_bdrop: assert property (p_bdrop) else $error("write response not released");
  a_brise: assert property (p_brise) else $error("write response late");
  a_rrise: assert property (p_rrise) else $error("read answer late");
  a_rdrop: assert property (p_rdrop) else $error("read answer not released");
  a_awdrop: assert property (p_awdrop) else $error("address ready held after take");
  a_txlow: assert property (p_txlow) else $error("tx flag below minimum");
  a_rxlow: assert property (p_rxlow) else $error("rx flag below minimum");
  c_tx: cover property (O_TX_HALF_FLAG);
  c_rx: cover property (O_RX_HALF_FLAG);
  c_irq: cover property (O_IRQ);
endmodule
bind ufm_marker ufm_marker_monitor #(.CNT_W(CNT_W)) u_mon (.I_CLK, .I_SRST, .I_TX_EMPTY_SLOTS, .I_RX_BYTES_HELD,
  .I_AWVALID, .O_AWREADY, .O_BVALID, .I_BREADY, .I_ARVALID, .O_ARREADY, .O_RVALID, .I_RREADY,
  .O_TX_HALF_FLAG, .O_RX_HALF_FLAG, .O_IRQ);
`default_nettype wire

// File: verif/ufm_marker_bench.sv
// Self-checking bench of the queue threshold marker.
`timescale 1ns/10ps
`default_nettype none
module ufm_marker_bench;
  import ufm_pkg::*;
  localparam int    CNT_W = 7;
  logic             I_CLK, I_SRST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
  logic [CNT_W-1:0] I_TX_EMPTY_SLOTS, I_RX_BYTES_HELD;
  logic [3:0]       I_AWADDR, I_WSTRB, I_ARADDR;
  logic [31:0]      I_WDATA, O_RDATA;
  logic [1:0]       O_BRESP, O_RRESP;
  logic             O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_TX_HALF_FLAG, O_RX_HALF_FLAG, O_IRQ;
  logic [33:0]      exp_q[$];
  int               n_mismatch = 0, cmp_count = 0, cyc = 0, seed = 59061, c, rx, tx;
  ufm_marker #(.CNT_W(CNT_W)) DUT (.I_CLK, .I_SRST, .I_TX_EMPTY_SLOTS, .I_RX_BYTES_HELD, .I_AWADDR, .I_AWVALID,
    .O_AWREADY, .I_WDATA, .I_WSTRB, .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID,
    .O_ARREADY, .O_RDATA, .O_RRESP, .O_RVALID, .I_RREADY, .O_TX_HALF_FLAG, .O_RX_HALF_FLAG, .O_IRQ);
  // ****************************************************************
  // Bus tasks and checks
  // ****************************************************************
  task automatic err(input string m);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk(input logic g, input logic x);
    cmp_count++;
    if (g !== x) err("flag level");
  endtask
  function automatic logic hit(input int k, input int n);
    return k != 0 && n >= 4 * k;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r = UFM_RESP_OKAY);
    @(posedge I_CLK);
    I_AWADDR <= a;
    I_WDATA <= d;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    // Ready for the response comes late so that the held response is seen.
    do
    begin
      @(posedge I_CLK);
      if (O_AWREADY === 1'b1) I_AWVALID <= 1'b0;
      if (O_WREADY === 1'b1) I_WVALID <= 1'b0;
      if (O_BVALID === 1'b1 && I_BREADY !== 1'b1) I_BREADY <= 1'b1;
    end
    while (!(O_BVALID === 1'b1 && I_BREADY === 1'b1));
    I_BREADY <= 1'b0;
    cmp_count++;
    if (O_BRESP !== r) err("write response");
  endtask
  task automatic rd(input logic [3:0] a, input logic [1:0] r, input logic [31:0] d);
    @(posedge I_CLK);
    exp_q.push_back({r, d});
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    do
    begin
      @(posedge I_CLK);
      if (O_ARREADY === 1'b1) I_ARVALID <= 1'b0;
    end
    while (O_RVALID !== 1'b1);
    I_RREADY <= 1'b0;
  endtask
  always @(posedge I_CLK)
    if (O_RVALID === 1'b1 && I_RREADY === 1'b1)
    begin
      cmp_count++;
      if ({O_RRESP, O_RDATA} !== exp_q.pop_front()) err("read data");
    end
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge I_CLK)
  begin
    cyc++;
    if (cyc == 20000) err("timeout");
    if (cyc == 20000) finish_test;
  end
  initial
  begin
    I_CLK = 1'b0;
    forever #2.5 I_CLK = ~I_CLK;
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_AWADDR, I_ARADDR, I_WDATA} = '0;
    {I_TX_EMPTY_SLOTS, I_RX_BYTES_HELD} = '0;
    I_WSTRB = 4'hF;
    I_SRST = 1'b1;
    repeat (5) @(posedge I_CLK);
    I_SRST <= 1'b0;
    rd(UFM_OFF_THRESH, UFM_RESP_OKAY, 32'h0);
    rd(UFM_OFF_STATUS, UFM_RESP_OKAY, 32'h0);
    rd(4'h2, UFM_RESP_SLVERR, 32'h0);
    wr(4'h6, 32'h0, UFM_RESP_SLVERR);
    wr(UFM_OFF_THRESH, 32'h00000F0F);
    rd(UFM_OFF_THRESH, UFM_RESP_OKAY, 32'h00000F0F);
    for (int k = 0; k < 16; k++)
    begin
      wr(UFM_OFF_THRESH, 32'(k * 257));
      for (int j = 0; j < 3; j++)
      begin
        c = $random(seed);
        rx = (j == 0 ? 4 * k - 1 : j == 1 ? 4 * k : c) & 127;
        tx = (j == 1 ? 4 * k - 1 : j == 0 ? 4 * k : c >> 8) & 127;
        @(posedge I_CLK);
        I_RX_BYTES_HELD <= CNT_W'(rx);
        I_TX_EMPTY_SLOTS <= CNT_W'(tx);
        repeat (2) @(posedge I_CLK);
        chk(O_RX_HALF_FLAG, hit(k, rx));
        chk(O_TX_HALF_FLAG, hit(k, tx));
      end
    end
    @(posedge I_CLK);
    {I_TX_EMPTY_SLOTS, I_RX_BYTES_HELD} <= '0;
    I_WSTRB <= 4'h2;
    wr(UFM_OFF_THRESH, 32'h00000101);
    rd(UFM_OFF_THRESH, UFM_RESP_OKAY, 32'h0000010F);
    I_WSTRB <= 4'hF;
    wr(UFM_OFF_THRESH, 32'h00000101);
    wr(UFM_OFF_CLEAR, 32'h3);
    rd(UFM_OFF_STATUS, UFM_RESP_OKAY, 32'h0);
    @(posedge I_CLK);
    I_RX_BYTES_HELD <= 7'h04;
    rd(UFM_OFF_STATUS, UFM_RESP_OKAY, 32'h1);
    chk(O_IRQ, 1'b0);
    wr(UFM_OFF_ENABLE, 32'h3);
    repeat (3) @(posedge I_CLK);
    chk(O_IRQ, 1'b1);
    {I_TX_EMPTY_SLOTS, I_RX_BYTES_HELD} <= {7'h04, 7'h00};
    rd(UFM_OFF_STATUS, UFM_RESP_OKAY, 32'h3);
    I_TX_EMPTY_SLOTS <= 7'h00;
    wr(UFM_OFF_CLEAR, 32'h3);
    repeat (3) @(posedge I_CLK);
    chk(O_IRQ, 1'b0);
    rd(UFM_OFF_ENABLE, UFM_RESP_OKAY, 32'h3);
    rd(UFM_OFF_CLEAR, UFM_RESP_OKAY, 32'h0);
    finish_test;
  end
endmodule
`default_nettype wire
